// ### core/rpc_cfg.sv
// Receive-port control channel configuration bank, all ports
`timescale 1ns/10ps
module rpc_cfg
   import rpc_pkg::*;
#(
   parameter int NUM_PORTS = 4
)
(
   // Clock, reset and rate strap
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [2:0] strap_rate,
   // Register access from the I2C front end
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_local,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Forward-channel loads per port
   input wire logic [NUM_PORTS-1:0] fc_load,
   input wire logic [2*NUM_PORTS-1:0] fc_gpio,
   input wire logic [7*NUM_PORTS-1:0] fc_id,
   // Per-port controls
   output logic [NUM_PORTS-1:0] pass_all,
   output logic [NUM_PORTS-1:0] pass_decoded,
   output logic [NUM_PORTS-1:0] auto_ack,
   output logic [NUM_PORTS-1:0] back_channel_en,
   output logic [NUM_PORTS-1:0] back_channel_crc_on,
   output logic [3*NUM_PORTS-1:0] back_channel_rate_code,
   output logic [NUM_PORTS-1:0] rate_reserved,
   output logic [3*NUM_PORTS-1:0] forward_gpio_lines,
   output logic [7*NUM_PORTS-1:0] remote_id
);
   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   // The select byte has one bit per port, so more than eight ports cannot be reached
   // Refused at elaboration rather than silently dropping the upper ports
   if (NUM_PORTS < 1 || NUM_PORTS > 8) begin : g_bad_ports
      $error("rpc_cfg: NUM_PORTS must be 1 to 8");
   end

   // ----------------------------------------
   // Port select
   // ----------------------------------------
   logic [7:0] port_sel_r, port_sel_nxt;
   logic [7:0] rdata_nxt;
   logic [7:0] bcc_v [NUM_PORTS];
   logic [7:0] fpc_v [NUM_PORTS];
   logic [7:0] rsa_v [NUM_PORTS];

   // Select byte: one bit per port, so broadcast writes reach several copies
   always_comb begin
      port_sel_nxt = port_sel_r;
      if (reg_wr && reg_addr == RPC_PORT_SEL_OFS) begin
         port_sel_nxt = reg_wdata;
      end
   end

   // Select register; reset reaches port 0 only, so a blind write never broadcasts
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         port_sel_r <= RPC_PORT_SEL_RST;
      end else begin
         port_sel_r <= port_sel_nxt;
      end
   end

   // ----------------------------------------
   // Per-port banks
   // ----------------------------------------
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      // Every port sees the same write bus; only its select bit gates the strobe
      rpc_port_if pif ();
      assign pif.wr_en = reg_wr && port_sel_r[p];
      assign pif.wr_local = reg_local;
      assign pif.addr = reg_addr;
      assign pif.wdata = reg_wdata;
      // Forward-channel fields are packed per port on the flat inputs
      assign pif.fc_load = fc_load[p];
      assign pif.fc_gpio = fc_gpio[2*p +: 2];
      assign pif.fc_id = fc_id[7*p +: 7];
      assign bcc_v[p] = pif.bcc;
      assign fpc_v[p] = pif.fpc;
      assign rsa_v[p] = pif.rsa;
      // One bank per port, identical and independent of the others
      rpc_port_bank u_bank (
         .core_clk(core_clk),
         .rst_b(rst_b),
         .strap_rate(strap_rate),
         .pif(pif)
      );
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [NUM_PORTS-1:0] pa_nxt, pd_nxt, aa_nxt, bce_nxt, crc_nxt, rr_nxt;
   logic [3*NUM_PORTS-1:0] rate_nxt, gpio_nxt;
   logic [7*NUM_PORTS-1:0] id_nxt;

   // Read returns the lowest selected port's copy
   // With several bits set the other copies stay hidden; select one port to read it
   // Unmapped offsets and an empty select read as zero, never a stale byte
   always_comb begin
      logic found;
      found = 1'b0;
      rdata_nxt = reg_rdata;
      if (reg_rd) begin
         rdata_nxt = RPC_ZERO;
         if (reg_addr == RPC_PORT_SEL_OFS) begin
            rdata_nxt = port_sel_r;
         end
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_sel_r[p] && !found) begin
               found = 1'b1;
               if (reg_addr == RPC_BCC_OFS) begin
                  rdata_nxt = bcc_v[p];
               end else if (reg_addr == RPC_FPC_OFS) begin
                  rdata_nxt = fpc_v[p];
               end else if (reg_addr == RPC_RSA_OFS) begin
                  rdata_nxt = rsa_v[p];
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Decoded controls
   // ----------------------------------------
   // Channel controls: pass-through, acknowledge, enable and CRC
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         pa_nxt[p] = bcc_v[p][RPC_BCC_PASS_ALL];
         pd_nxt[p] = bcc_v[p][RPC_BCC_PASS_DEC];
         aa_nxt[p] = bcc_v[p][RPC_BCC_AUTO_ACK];
         // Channel stays up if forced, else only while passing traffic
         bce_nxt[p] = bcc_v[p][RPC_BCC_ALWAYS_ON] | pa_nxt[p] | pd_nxt[p];
         crc_nxt[p] = bcc_v[p][RPC_BCC_CRC_ON];
      end
   end

   // Rate code and its reserved flag
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         rate_nxt[3*p +: 3] = bcc_v[p][2:0];
         // Reserved codes are kept as written; the flag lets the link logic refuse them
         rr_nxt[p] = !(bcc_v[p][2:0] == RPC_RATE_2M5 || bcc_v[p][2:0] == RPC_RATE_10M
                       || bcc_v[p][2:0] == RPC_RATE_50M);
      end
   end

   // Forward-path GPIO count and remote ID
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         // Count code 11 means four lines, not three
         unique case (fpc_v[p][1:0])
            RPC_GPIO_NONE: gpio_nxt[3*p +: 3] = RPC_LINES_NONE;
            RPC_GPIO_ONE: gpio_nxt[3*p +: 3] = RPC_LINES_ONE;
            RPC_GPIO_TWO: gpio_nxt[3*p +: 3] = RPC_LINES_TWO;
            RPC_GPIO_FOUR: gpio_nxt[3*p +: 3] = RPC_LINES_FOUR;
         endcase
         id_nxt[7*p +: 7] = rsa_v[p][7:1];
      end
   end

   // ----------------------------------------
   // Register stage
   // ----------------------------------------
   // Read data; holds between reads so a slow front end can pick it up late
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reg_rdata <= RPC_ZERO;
      end else begin
         reg_rdata <= rdata_nxt;
      end
   end

   // Controls; one cycle behind the register copies, every output from a flop
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         // Pass-through and acknowledge off
         pass_all <= '0;
         pass_decoded <= '0;
         auto_ack <= '0;
         // Back channel and its CRC on until software says otherwise
         back_channel_en <= '1;
         back_channel_crc_on <= '1;
         back_channel_rate_code <= '0;
         rate_reserved <= '0;
         // Forward-path values wait for the first frame
         forward_gpio_lines <= '0;
         remote_id <= '0;
      end else begin
         pass_all <= pa_nxt;
         pass_decoded <= pd_nxt;
         auto_ack <= aa_nxt;
         back_channel_en <= bce_nxt;
         back_channel_crc_on <= crc_nxt;
         back_channel_rate_code <= rate_nxt;
         rate_reserved <= rr_nxt;
         forward_gpio_lines <= gpio_nxt;
         remote_id <= id_nxt;
      end
   end
endmodule

// ### core/rpc_pkg.sv
// Package for the receive-port control channel configuration bank
package rpc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] RPC_PORT_SEL_OFS = 8'h4C;
   localparam logic [7:0] RPC_BCC_OFS = 8'h58;
   localparam logic [7:0] RPC_FPC_OFS = 8'h59;
   localparam logic [7:0] RPC_RSA_OFS = 8'h5B;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int RPC_BCC_PASS_ALL = 7;
   localparam int RPC_BCC_PASS_DEC = 6;
   localparam int RPC_BCC_AUTO_ACK = 5;
   localparam int RPC_BCC_ALWAYS_ON = 4;
   localparam int RPC_BCC_CRC_ON = 3;
   localparam int RPC_FPC_BLOCK = 7;
   localparam int RPC_RSA_HOLD = 0;
   // ----------------------------------------
   // Reset values and masks
   // ----------------------------------------
   localparam logic [4:0] RPC_BCC_HI_RST = 5'h03;
   localparam logic [7:0] RPC_FPC_RST = 8'h00;
   localparam logic [7:0] RPC_RSA_RST = 8'h00;
   localparam logic [7:0] RPC_FPC_MASK = 8'h83;
   localparam logic [7:0] RPC_ZERO = 8'h00;
   localparam logic [7:0] RPC_PORT_SEL_RST = 8'h01;
   // ----------------------------------------
   // Back-channel rate codes
   // ----------------------------------------
   localparam logic [2:0] RPC_RATE_2M5 = 3'h0;
   localparam logic [2:0] RPC_RATE_10M = 3'h2;
   localparam logic [2:0] RPC_RATE_50M = 3'h6;
   // ----------------------------------------
   // Forward GPIO count codes and line counts
   // ----------------------------------------
   localparam logic [1:0] RPC_GPIO_NONE = 2'h0;
   localparam logic [1:0] RPC_GPIO_ONE = 2'h1;
   localparam logic [1:0] RPC_GPIO_TWO = 2'h2;
   localparam logic [1:0] RPC_GPIO_FOUR = 2'h3;
   localparam logic [2:0] RPC_LINES_NONE = 3'h0;
   localparam logic [2:0] RPC_LINES_ONE = 3'h1;
   localparam logic [2:0] RPC_LINES_TWO = 3'h2;
   localparam logic [2:0] RPC_LINES_FOUR = 3'h4;
endpackage

// ### core/rpc_port_if.sv
// Interface carrying one port's register access, forward-channel loads and register copies
`timescale 1ns/10ps
interface rpc_port_if;
   logic wr_en;
   logic wr_local;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic fc_load;
   logic [1:0] fc_gpio;
   logic [6:0] fc_id;
   logic [7:0] bcc;
   logic [7:0] fpc;
   logic [7:0] rsa;
   modport bank (input wr_en, wr_local, addr, wdata, fc_load, fc_gpio, fc_id, output bcc, fpc, rsa);
   modport ctl (output wr_en, wr_local, addr, wdata, fc_load, fc_gpio, fc_id, input bcc, fpc, rsa);
endinterface

// ### core/rpc_port_bank.sv
// One receive port's copy of the configuration registers
`timescale 1ns/10ps
module rpc_port_bank
   import rpc_pkg::*;
(
   // Clock, reset and rate strap
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [2:0] strap_rate,
   // Access
   rpc_port_if.bank pif
);
   logic [7:0] bcc_r, bcc_nxt;
   logic [7:0] fpc_r, fpc_nxt;
   logic [7:0] rsa_r, rsa_nxt;
   logic strap_pend_r, strap_pend_nxt;

   // Next-state of the three registers
   always_comb begin
      bcc_nxt = bcc_r;
      fpc_nxt = fpc_r;
      rsa_nxt = rsa_r;
      strap_pend_nxt = 1'b0;
      // Strap caught on the first clock after reset release
      if (strap_pend_r) begin
         bcc_nxt[2:0] = strap_rate;
      end
      if (pif.wr_en && pif.addr == RPC_BCC_OFS) begin
         bcc_nxt[7:5] = pif.wdata[7:5];
         // Rate is taken as written; a remote rate change relies on auto-ack set beforehand
         bcc_nxt[3:0] = pif.wdata[3:0];
         // Remote writes cannot clear bit 4, so they cannot drop a back channel that bit 4 holds on; they can still clear bits 7 and 6
         if (pif.wr_local) begin
            bcc_nxt[RPC_BCC_ALWAYS_ON] = pif.wdata[RPC_BCC_ALWAYS_ON];
         end
      end
      // Forward-channel load happens unless blocked
      if (pif.fc_load && !fpc_r[RPC_FPC_BLOCK]) begin
         fpc_nxt[1:0] = pif.fc_gpio;
      end
      if (pif.fc_load && !rsa_r[RPC_RSA_HOLD]) begin
         rsa_nxt[7:1] = pif.fc_id;
      end
      // A register write, local or remote, wins in the same cycle as a load
      if (pif.wr_en && pif.addr == RPC_FPC_OFS) begin
         fpc_nxt = pif.wdata & RPC_FPC_MASK;
      end
      if (pif.wr_en && pif.addr == RPC_RSA_OFS) begin
         rsa_nxt = pif.wdata;
      end
   end

   // Register stage
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         bcc_r <= {RPC_BCC_HI_RST, RPC_RATE_2M5};
         fpc_r <= RPC_FPC_RST;
         rsa_r <= RPC_RSA_RST;
         strap_pend_r <= 1'b1;
      end else begin
         bcc_r <= bcc_nxt;
         fpc_r <= fpc_nxt;
         rsa_r <= rsa_nxt;
         strap_pend_r <= strap_pend_nxt;
      end
   end

   assign pif.bcc = bcc_r;
   assign pif.fpc = fpc_r;
   assign pif.rsa = rsa_r;
endmodule

// ### tb/rpc_cfg_sva.sv
// Checker for the receive-port configuration bank
`timescale 1ns/10ps
module rpc_cfg_sva
   import rpc_pkg::*;
#(parameter int NUM_PORTS = 4)
(
   // Clock, reset and access
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_local,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // Forward-channel loads
   input wire logic [NUM_PORTS-1:0] fc_load,
   input wire logic [2*NUM_PORTS-1:0] fc_gpio,
   input wire logic [7*NUM_PORTS-1:0] fc_id,
   // Controls
   input wire logic [NUM_PORTS-1:0] pass_all,
   input wire logic [NUM_PORTS-1:0] pass_decoded,
   input wire logic [NUM_PORTS-1:0] auto_ack,
   input wire logic [NUM_PORTS-1:0] back_channel_en,
   input wire logic [3*NUM_PORTS-1:0] back_channel_rate_code,
   input wire logic [NUM_PORTS-1:0] rate_reserved,
   input wire logic [3*NUM_PORTS-1:0] forward_gpio_lines,
   input wire logic [7*NUM_PORTS-1:0] remote_id
);
   // ---
   // Port 0 shadow state
   // ---
   logic [7:0] sel_r, sel_nxt;
   logic blk_r, blk_nxt, hold_r, hold_nxt, w0, ld0, b0;
   logic [2:0] gexp;
   // Only traffic reaching port 0 is tracked
   assign w0 = reg_wr && sel_r[0];
   assign b0 = w0 && reg_addr == RPC_BCC_OFS;
   assign ld0 = fc_load[0] && !reg_wr;
   assign gexp = {fc_gpio[1:0] == 2'h3, fc_gpio[1:0] == 2'h2, fc_gpio[1:0] == 2'h1};
   always_comb begin
      sel_nxt = (reg_wr && reg_addr == RPC_PORT_SEL_OFS) ? reg_wdata : sel_r;
      blk_nxt = (w0 && reg_addr == RPC_FPC_OFS) ? reg_wdata[RPC_FPC_BLOCK] : blk_r;
      hold_nxt = (w0 && reg_addr == RPC_RSA_OFS) ? reg_wdata[RPC_RSA_HOLD] : hold_r;
   end
   always_ff @(posedge core_clk) begin
      sel_r <= rst_b ? sel_nxt : 8'h01;
      blk_r <= rst_b && blk_nxt;
      hold_r <= rst_b && hold_nxt;
   end
   // ---
   // Properties
   // ---
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_bc_enable: assert property (((pass_all | pass_decoded) & ~back_channel_en) == '0)
      else $error("back channel off");
   a_rate_flag: assert property (rate_reserved[0] == !(back_channel_rate_code[2:0] inside {3'h0, 3'h2, 3'h6}))
      else $error("rate flag wrong");
   a_remote_ao: assert property ((b0 && !reg_local && back_channel_en[0] && !pass_all[0] && !pass_decoded[0])
      |-> ##2 back_channel_en[0]) else $error("remote write took bit 4");
   a_pass_all: assert property (b0 |-> ##2 pass_all[0] == $past(reg_wdata[7], 2))
      else $error("pass_all wrong");
   a_auto_ack: assert property (b0 |-> ##2 auto_ack[0] == $past(reg_wdata[5], 2))
      else $error("auto_ack wrong");
   a_gpio_block: assert property (ld0 && blk_r |-> ##2 $stable(forward_gpio_lines[2:0]))
      else $error("blocked load taken");
   a_gpio_load: assert property (ld0 && !blk_r |-> ##2 forward_gpio_lines[2:0] == $past(gexp, 2))
      else $error("gpio count wrong");
   a_id_load: assert property (ld0 && !hold_r |-> ##2 remote_id[6:0] == $past(fc_id[6:0], 2))
      else $error("id not loaded");
   a_id_hold: assert property (ld0 && hold_r |-> ##2 $stable(remote_id[6:0]))
      else $error("frozen id changed");
   c_remote: cover property (b0 && !reg_local);
   c_blocked: cover property (ld0 && blk_r);
   c_reserved: cover property (rate_reserved[0]);
endmodule

// ### tb/rpc_ser_model.sv
// Behavioural remote serializer driving forward-channel loads
`timescale 1ns/10ps
module rpc_ser_model #(parameter int NUM_PORTS = 4)
(
   // Clock
   input wire logic core_clk,
   // Frame contents
   output logic [NUM_PORTS-1:0] fc_load,
   output logic [2*NUM_PORTS-1:0] fc_gpio,
   output logic [7*NUM_PORTS-1:0] fc_id
);
   initial begin
      fc_load = '0;
      fc_gpio = '0;
      fc_id = '0;
   end
   // One frame after gap cycles; fields scrambled after so stale data never looks valid
   task automatic send(input int p, input logic [1:0] g, input logic [6:0] id, input int gap);
      repeat (gap) @(negedge core_clk);
      @(negedge core_clk);
      fc_load[p] = 1'b1;
      fc_gpio[2*p+:2] = g;
      fc_id[7*p+:7] = id;
      @(negedge core_clk);
      fc_load = '0;
      fc_gpio = ~fc_gpio;
      fc_id = ~fc_id;
      repeat (2) @(negedge core_clk);
   endtask
endmodule

// ### tb/rpc_cfg_tb_top.sv
// Top testbench for the receive-port configuration bank
`timescale 1ns/10ps
module rpc_cfg_tb_top;
   import rpc_pkg::*;
   // ---
   // Signals
   // ---
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] strap_rate = RPC_RATE_50M;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic reg_local = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, fc_gpio;
   logic [3:0] fc_load, pass_all, pass_decoded, auto_ack, back_channel_en, back_channel_crc_on, rate_reserved;
   logic [27:0] fc_id, remote_id;
   logic [11:0] back_channel_rate_code, forward_gpio_lines;
   int mismatches = 0;
   int total_checks = 0;
   always #20 core_clk = ~core_clk;
   rpc_ser_model ser_u (.core_clk, .fc_load, .fc_gpio, .fc_id);
   rpc_cfg dut_u (.core_clk, .rst_b, .strap_rate, .reg_wr, .reg_rd, .reg_local, .reg_addr, .reg_wdata, .reg_rdata,
      .fc_load, .fc_gpio, .fc_id, .pass_all, .pass_decoded, .auto_ack, .back_channel_en, .back_channel_crc_on,
      .back_channel_rate_code, .rate_reserved, .forward_gpio_lines, .remote_id);
   // ---
   // Shared tasks
   // ---
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobe for one edge, then wait out the two-cycle path to the controls
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic loc);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      reg_local = loc;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
      repeat (2) @(negedge core_clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ---
   // Scenarios
   // ---
   task automatic t_reset;
      rdc(RPC_BCC_OFS, 8'h1E);
      chk({4'h0, back_channel_crc_on}, 8'h0F);
      chk({4'h0, pass_all | pass_decoded | auto_ack}, 8'h00);
      rdc(RPC_FPC_OFS, 8'h00);
      rdc(RPC_RSA_OFS, 8'h00);
      rdc(RPC_PORT_SEL_OFS, 8'h01);
      rdc(8'h5A, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_bcc;
      wr(RPC_BCC_OFS, 8'h02, 1'b1);
      chk({4'h0, back_channel_en}, 8'h0E);
      chk({4'h0, back_channel_crc_on}, 8'h0E);
      wr(RPC_BCC_OFS, 8'h42, 1'b1);
      chk({4'h0, back_channel_en & pass_decoded}, 8'h01);
      wr(RPC_BCC_OFS, 8'h82, 1'b1);
      chk({4'h0, back_channel_en & pass_all}, 8'h01);
      // Auto-ack goes on locally before the rate is changed from the remote side
      wr(RPC_BCC_OFS, 8'h32, 1'b1);
      wr(RPC_BCC_OFS, 8'h26, 1'b0);
      rdc(RPC_BCC_OFS, 8'h36);
      chk({4'h0, auto_ack}, 8'h01);
      for (int c = 0; c < 8; c++) begin
         wr(RPC_BCC_OFS, 8'h10 | c[7:0], 1'b1);
         chk({5'h00, back_channel_rate_code[2:0]}, c[7:0]);
         chk({7'h00, rate_reserved[0]}, {7'h00, !(c == 0 || c == 2 || c == 6)});
      end
      $display("t_bcc done");
   endtask
   task automatic t_fpc;
      ser_u.send(0, 2'h3, 7'h55, 0);
      chk({5'h00, forward_gpio_lines[2:0]}, 8'h04);
      rdc(RPC_FPC_OFS, 8'h03);
      wr(RPC_FPC_OFS, 8'hFD, 1'b1);
      rdc(RPC_FPC_OFS, 8'h81);
      ser_u.send(0, 2'h2, 7'h55, 3);
      chk({5'h00, forward_gpio_lines[2:0]}, 8'h01);
      wr(RPC_FPC_OFS, 8'h02, 1'b1);
      ser_u.send(0, 2'h0, 7'h55, 0);
      chk({5'h00, forward_gpio_lines[2:0]}, 8'h00);
      ser_u.send(0, 2'h2, 7'h55, 0);
      chk({5'h00, forward_gpio_lines[2:0]}, 8'h02);
      $display("t_fpc done");
   endtask
   task automatic t_rsa;
      ser_u.send(0, 2'h2, 7'h2A, 1);
      chk({1'b0, remote_id[6:0]}, 8'h2A);
      wr(RPC_RSA_OFS, 8'h25, 1'b1);
      ser_u.send(0, 2'h2, 7'h33, 0);
      chk({1'b0, remote_id[6:0]}, 8'h12);
      rdc(RPC_RSA_OFS, 8'h25);
      $display("t_rsa done");
   endtask
   task automatic t_port;
      wr(RPC_PORT_SEL_OFS, 8'h02, 1'b1);
      wr(RPC_BCC_OFS, 8'h80, 1'b1);
      rdc(RPC_BCC_OFS, 8'h80);
      chk({4'h0, pass_all}, 8'h02);
      ser_u.send(1, 2'h1, 7'h0F, 0);
      chk({5'h00, forward_gpio_lines[5:3]}, 8'h01);
      wr(RPC_PORT_SEL_OFS, 8'h01, 1'b1);
      rdc(RPC_BCC_OFS, 8'h17);
      // Two select bits: one write lands in both copies, a read returns the lowest
      wr(RPC_PORT_SEL_OFS, 8'h03, 1'b1);
      wr(RPC_BCC_OFS, 8'h50, 1'b1);
      chk({4'h0, pass_decoded}, 8'h03);
      rdc(RPC_BCC_OFS, 8'h50);
      $display("t_port done");
   endtask
   initial begin
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge core_clk);
      t_reset;
      t_bcc;
      t_fpc;
      t_rsa;
      t_port;
      end_sim;
   end
   // Watchdog at 10000 cycles, well beyond the roughly 150 the scenarios need
   initial begin
      #400000;
      mismatches++;
      end_sim;
   end
endmodule
bind rpc_cfg rpc_cfg_sva #(.NUM_PORTS(NUM_PORTS)) sva_u (.core_clk, .rst_b, .reg_wr, .reg_local, .reg_addr,
   .reg_wdata, .fc_load, .fc_gpio, .fc_id, .pass_all, .pass_decoded, .auto_ack, .back_channel_en,
   .back_channel_rate_code, .rate_reserved, .forward_gpio_lines, .remote_id);
